// File: sla_pkg.sv
package sla_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_OUT_FMT   = 8'h14;
    localparam logic [7:0] ADDR_SWING     = 8'h15;
    localparam logic [7:0] ADDR_SYNC_OPT  = 8'h3a;
    localparam logic [7:0] ADDR_QUICK_CFG = 8'h5e;
    localparam logic [7:0] ADDR_LINK_CTL  = 8'h5f;
    localparam logic [7:0] ADDR_LANE_POL  = 8'h60;
    localparam logic [7:0] ADDR_LANE_SCR  = 8'h6e;
    localparam logic [7:0] ADDR_OCT_FRM   = 8'h6f;
    localparam logic [7:0] ADDR_CONV_CNT  = 8'h71;
    localparam logic [7:0] ADDR_SMP_FRM   = 8'h74;
    localparam logic [7:0] ADDR_DENSITY   = 8'h75;
    localparam logic [7:0] ADDR_REMAP_A   = 8'h82;
    localparam logic [7:0] ADDR_REMAP_B   = 8'h83;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0] RST_OUT_FMT   = 8'h01;
    localparam logic [7:0] RST_SWING     = 8'h00;
    localparam logic [7:0] RST_SYNC_OPT  = 8'h00;
    localparam logic [7:0] RST_QUICK_CFG = 8'h42;
    localparam logic [7:0] RST_LINK_CTL  = 8'h10;
    localparam logic [7:0] RST_LANE_POL  = 8'h00;
    localparam logic       RST_SCR_EN    = 1'b1;
    localparam logic [7:0] RST_REMAP_A   = 8'h10;
    localparam logic [7:0] RST_REMAP_B   = 8'h32;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and encodings
    localparam int         BIT_LINK_DIS  = 0;
    localparam int         BIT_LANE_SYNC = 4;
    localparam int         BIT_POL_INV   = 1;
    localparam int         BIT_SCR_EN    = 7;
    localparam int         BIT_SYNC_INV  = 3;
    localparam int         BIT_SYSREF_IGN = 4;
    localparam logic [1:0] FMT_OFFSET_BIN = 2'b00;
    localparam logic [1:0] FMT_TWOS_COMP  = 2'b01;
    localparam logic [7:0] SMP_PER_FRM   = 8'h01;
    localparam logic       HIGH_DENSITY_VAL = 1'b0;
    localparam logic [4:0] CF_VAL        = 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Link geometry and characters
    localparam int         NUM_LANES     = 4;
    localparam int         NUM_CONV      = 4;
    localparam int         SMP_BITS      = 16;
    localparam int         FRAMES_PER_MF = 32;
    localparam logic [7:0] K28_7         = 8'hfc;
    localparam logic [7:0] K28_3         = 8'h7c;
    localparam logic [7:0] D28_7         = 8'hfc;
    localparam logic [7:0] D28_3         = 8'h7c;

    ////////////////////////////////////////////////////////////////////////////
    // Lane rate limit
    localparam int LANE_RATE_MAX_MBPS = 8000;
    localparam int SAMPLE_RATE_MSPS   = 125;
    localparam int LINE_NUM           = 10;
    localparam int LINE_DEN           = 8;

    typedef struct packed {
        logic [7:0] m;
        logic [7:0] l;
        logic [7:0] f;
    } sla_cfg_s;

    typedef struct packed {
        logic       k;
        logic [7:0] data;
    } sla_oct_s;

    localparam sla_cfg_s CFG_RST = '{m: 8'h04, l: 8'h02, f: 8'h04};

    function automatic sla_cfg_s sla_qc_decode(input logic [7:0] code, input sla_cfg_s hold);
        case (code)
            8'h41:   return '{m: 8'h04, l: 8'h01, f: 8'h08};
            8'h42:   return '{m: 8'h04, l: 8'h02, f: 8'h04};
            8'h44:   return '{m: 8'h04, l: 8'h04, f: 8'h02};
            8'h22:   return '{m: 8'h02, l: 8'h02, f: 8'h02};
            8'h21:   return '{m: 8'h02, l: 8'h01, f: 8'h04};
            8'h11:   return '{m: 8'h01, l: 8'h01, f: 8'h02};
            default: return hold;
        endcase
    endfunction : sla_qc_decode

    function automatic logic sla_rate_over(input sla_cfg_s c);
        int rate;
        rate = (int'(c.m) * SMP_BITS * LINE_NUM * SAMPLE_RATE_MSPS) / (LINE_DEN * int'(c.l));
        return rate > LANE_RATE_MAX_MBPS;
    endfunction : sla_rate_over

endpackage : sla_pkg

// File: sla_sync2.sv
`timescale 1ns/1ns
module sla_sync2 #(
    parameter int W = 2
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    // First stage is read only by the second stage
    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= '0;
            q_o    <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule : sla_sync2

// File: sla_align.sv
`timescale 1ns/1ns
module sla_align (
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  wire logic             en_i,
    input  wire logic [7:0]       data_i,
    input  wire logic             last_i,
    input  wire logic             mf_end_i,
    input  wire logic             scr_i,
    input  wire logic             lsync_i,
    output sla_pkg::sla_oct_s     oct_o
);
    logic [7:0] prev_r;
    logic       prev_vld_r;

    ////////////////////////////////////////////////////////////////////////////
    // Replacement decision
    wire        use_k283   = lsync_i & mf_end_i;
    wire        rep_plain  = !scr_i & last_i & prev_vld_r & (data_i == prev_r);
    wire [7:0]  scr_match  = use_k283 ? sla_pkg::D28_3 : sla_pkg::D28_7;
    wire        rep_scr    = scr_i & last_i & (data_i == scr_match);
    wire        rep        = rep_plain | rep_scr;
    wire [7:0]  rep_char   = use_k283 ? sla_pkg::K28_3 : sla_pkg::K28_7;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            oct_o      <= '0;
            prev_r     <= 8'h00;
            prev_vld_r <= 1'b0;
        end
        else
        begin
            oct_o.data <= rep ? rep_char : data_i;
            oct_o.k    <= rep & en_i;
            // Compare against the unreplaced octet, as the receiver restores it
            if (!en_i)
                prev_vld_r <= 1'b0;
            else if (last_i)
                prev_vld_r <= 1'b1;
            if (last_i)
                prev_r <= data_i;
        end
    end

    AST_K283: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (en_i && !scr_i && lsync_i && mf_end_i && last_i && prev_vld_r && data_i == prev_r)
        |=> (oct_o.k && oct_o.data == sla_pkg::K28_3))
        else $error("repeated multiframe end not sent as K28.3");

    AST_K287_SCR: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (en_i && scr_i && last_i && !mf_end_i && data_i == sla_pkg::D28_7)
        |=> (oct_o.k && oct_o.data == sla_pkg::K28_7))
        else $error("scrambled D28.7 frame end not replaced");

    AST_NOSYNC_K287: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (en_i && !lsync_i && last_i && (rep_plain || rep_scr)) |=> (oct_o.data == sla_pkg::K28_7))
        else $error("replacement without lane sync is not K28.7");

    AST_CTRL_ONLY_LAST: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!last_i) |=> (!oct_o.k))
        else $error("control flag outside last octet of frame");
endmodule : sla_align

// File: sla_link_top.sv
`timescale 1ns/1ns
module sla_link_top (
    input  wire logic                              core_clk_i,
    input  wire logic                              rst_i,
    input  wire logic                              reg_we_i,
    input  wire logic [7:0]                        reg_addr_i,
    input  wire logic [7:0]                        reg_wdata_i,
    output logic      [7:0]                        reg_rdata_o,
    input  wire logic [sla_pkg::NUM_CONV-1:0][15:0] samples_i,
    output logic                                   sample_take_o,
    input  wire logic                              sync_req_n_i,
    input  wire logic                              sysref_i,
    output logic                                   sync_req_o,
    output logic                                   sysref_evt_o,
    output logic                                   link_active_o,
    output logic                                   rate_over_o,
    output logic      [sla_pkg::NUM_LANES-1:0]     lane_en_o,
    output sla_pkg::sla_oct_s [sla_pkg::NUM_LANES-1:0] lane_octet_o,
    output logic      [sla_pkg::NUM_LANES-1:0]     lane_invert_o,
    output logic      [7:0]                        drive_swing_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0]        fmt_r;
    logic [7:0]        swing_r;
    logic [7:0]        syncopt_r;
    logic [7:0]        qc_r;
    logic [7:0]        ctl_r;
    logic [7:0]        pol_r;
    logic              scr_en_r;
    logic [7:0]        remap_a_r;
    logic [7:0]        remap_b_r;
    logic [7:0]        rd_nxt;
    sla_pkg::sla_cfg_s cfg_r;
    sla_pkg::sla_cfg_s cfg_nxt;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            fmt_r     <= sla_pkg::RST_OUT_FMT;
            swing_r   <= sla_pkg::RST_SWING;
            syncopt_r <= sla_pkg::RST_SYNC_OPT;
            qc_r      <= sla_pkg::RST_QUICK_CFG;
            ctl_r     <= sla_pkg::RST_LINK_CTL;
            pol_r     <= sla_pkg::RST_LANE_POL;
            scr_en_r  <= sla_pkg::RST_SCR_EN;
            remap_a_r <= sla_pkg::RST_REMAP_A;
            remap_b_r <= sla_pkg::RST_REMAP_B;
        end
        else if (reg_we_i)
        begin
            case (reg_addr_i)
                sla_pkg::ADDR_OUT_FMT:   fmt_r     <= reg_wdata_i;
                sla_pkg::ADDR_SWING:     swing_r   <= reg_wdata_i;
                sla_pkg::ADDR_SYNC_OPT:  syncopt_r <= reg_wdata_i;
                sla_pkg::ADDR_QUICK_CFG: qc_r      <= reg_wdata_i;
                sla_pkg::ADDR_LINK_CTL:  ctl_r     <= reg_wdata_i;
                sla_pkg::ADDR_LANE_POL:  pol_r     <= reg_wdata_i;
                sla_pkg::ADDR_LANE_SCR:  scr_en_r  <= reg_wdata_i[sla_pkg::BIT_SCR_EN];
                sla_pkg::ADDR_REMAP_A:   remap_a_r <= reg_wdata_i;
                sla_pkg::ADDR_REMAP_B:   remap_b_r <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Decoded M, L and F only move while the link is held disabled, so a
    // careless quick configuration write during traffic cannot tear a frame apart
    wire link_dis  = ctl_r[sla_pkg::BIT_LINK_DIS];
    wire lsync_en  = ctl_r[sla_pkg::BIT_LANE_SYNC];
    wire rate_over = sla_pkg::sla_rate_over(cfg_r);
    wire active    = !link_dis && !rate_over;

    assign cfg_nxt = link_dis ? sla_pkg::sla_qc_decode(qc_r, cfg_r) : cfg_r;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            cfg_r <= sla_pkg::CFG_RST;
        else
            cfg_r <= cfg_nxt;
    end

    always_comb
    begin
        case (reg_addr_i)
            sla_pkg::ADDR_OUT_FMT:   rd_nxt = fmt_r;
            sla_pkg::ADDR_SWING:     rd_nxt = swing_r;
            sla_pkg::ADDR_SYNC_OPT:  rd_nxt = syncopt_r;
            sla_pkg::ADDR_QUICK_CFG: rd_nxt = qc_r;
            sla_pkg::ADDR_LINK_CTL:  rd_nxt = ctl_r;
            sla_pkg::ADDR_LANE_POL:  rd_nxt = pol_r;
            sla_pkg::ADDR_LANE_SCR:  rd_nxt = {scr_en_r, 2'b00, cfg_r.l[4:0]};
            sla_pkg::ADDR_OCT_FRM:   rd_nxt = cfg_r.f;
            sla_pkg::ADDR_CONV_CNT:  rd_nxt = cfg_r.m;
            sla_pkg::ADDR_SMP_FRM:   rd_nxt = sla_pkg::SMP_PER_FRM;
            sla_pkg::ADDR_DENSITY:   rd_nxt = {sla_pkg::HIGH_DENSITY_VAL, 2'b00, sla_pkg::CF_VAL};
            sla_pkg::ADDR_REMAP_A:   rd_nxt = remap_a_r;
            sla_pkg::ADDR_REMAP_B:   rd_nxt = remap_b_r;
            default:                 rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= rd_nxt;
    end

    assign lane_invert_o = {sla_pkg::NUM_LANES{pol_r[sla_pkg::BIT_POL_INV]}};
    assign drive_swing_o = swing_r;
    assign link_active_o = active;
    assign rate_over_o   = rate_over;

    ////////////////////////////////////////////////////////////////////////////
    // Sync request and system reference pins
    logic [1:0] pin_s;
    logic       sysref_d_r;

    sla_sync2 #(
        .W (2)
    ) u_pin_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .d_i        ({sysref_i, sync_req_n_i}),
        .q_o        (pin_s)
    );

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            sysref_d_r <= 1'b0;
        else
            sysref_d_r <= pin_s[1];
    end

    wire sync_lvl = syncopt_r[sla_pkg::BIT_SYNC_INV] ? pin_s[0] : !pin_s[0];
    assign sync_req_o   = active & sync_lvl;
    assign sysref_evt_o = pin_s[1] & !sysref_d_r & !syncopt_r[sla_pkg::BIT_SYSREF_IGN];

    ////////////////////////////////////////////////////////////////////////////
    // Frame and multiframe counters
    logic [2:0]                          oct_r;
    logic [4:0]                          frm_r;
    logic [sla_pkg::NUM_CONV-1:0][15:0]  smp_r;

    // F of 8 wraps to 0 in three bits, so F-1 is still right
    wire [2:0] f_last   = cfg_r.f[2:0] - 3'h1;
    wire       last_oct = (oct_r == f_last);
    wire       mf_last  = (frm_r == 5'(sla_pkg::FRAMES_PER_MF - 1));
    wire       take     = !active || last_oct;

    assign sample_take_o = active & last_oct;

    function automatic logic [15:0] fmt_conv(input logic [15:0] s, input logic [1:0] mode);
        return (mode == sla_pkg::FMT_OFFSET_BIN) ? {~s[15], s[14:0]} : s;
    endfunction : fmt_conv

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || !active)
        begin
            oct_r <= 3'h0;
            frm_r <= 5'h00;
        end
        else if (last_oct)
        begin
            oct_r <= 3'h0;
            frm_r <= mf_last ? 5'h00 : frm_r + 5'h01;
        end
        else
            oct_r <= oct_r + 3'h1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            smp_r <= '0;
        else if (take)
            for (int c = 0; c < sla_pkg::NUM_CONV; c++)
                smp_r[c] <= fmt_conv(samples_i[c], fmt_r[1:0]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Octet selection and lane remap
    // Octet k of a frame is converter k/2, even k carrying the upper byte
    function automatic logic [7:0] pick_oct(input logic [sla_pkg::NUM_CONV-1:0][15:0] s,
                                            input logic [7:0] idx);
        if (idx[7:1] >= 7'(sla_pkg::NUM_CONV))
            return 8'h00;
        return idx[0] ? s[idx[2:1]][7:0] : s[idx[2:1]][15:8];
    endfunction : pick_oct

    logic [sla_pkg::NUM_LANES-1:0][7:0] lg_oct;
    logic [sla_pkg::NUM_LANES-1:0][1:0] sel;
    logic [sla_pkg::NUM_LANES-1:0]      lane_en_r;

    assign sel[0] = remap_a_r[1:0];
    assign sel[1] = remap_a_r[5:4];
    assign sel[2] = remap_b_r[1:0];
    assign sel[3] = remap_b_r[5:4];

    for (genvar g = 0; g < sla_pkg::NUM_LANES; g++)
    begin : g_lane
        assign lg_oct[g] = pick_oct(smp_r, 8'(8'(g) * cfg_r.f) + {5'h00, oct_r});

        sla_align u_align (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .en_i       (active),
            .data_i     (lg_oct[sel[g]]),
            .last_i     (active & last_oct),
            .mf_end_i   (mf_last),
            .scr_i      (scr_en_r),
            .lsync_i    (lsync_en),
            .oct_o      (lane_octet_o[g])
        );

        always_ff @(posedge core_clk_i)
        begin
            if (rst_i)
                lane_en_r[g] <= 1'b0;
            else
                lane_en_r[g] <= active && ({6'h00, sel[g]} < cfg_r.l);
        end
    end

    assign lane_en_o = lane_en_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_POL_WRITE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (reg_we_i && reg_addr_i == sla_pkg::ADDR_LANE_POL)
        |=> (lane_invert_o == {4{$past(reg_wdata_i[1])}}))
        else $error("lane inversion does not follow polarity bit");

    AST_FMT_OFFSET: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (take && fmt_r[1:0] == sla_pkg::FMT_OFFSET_BIN)
        |=> (smp_r[0][15] != $past(samples_i[0][15])))
        else $error("offset binary sample sign not flipped");

    // Checked at the first edge after release, so the unset register at time zero is never seen
    AST_FMT_RESET: assert property (@(posedge core_clk_i)
        (rst_i ##1 !rst_i) |-> (fmt_r[1:0] == sla_pkg::FMT_TWOS_COMP))
        else $error("format not twos complement after reset");

    AST_SYSREF_IGN: assert property (@(posedge core_clk_i) disable iff (rst_i)
        syncopt_r[sla_pkg::BIT_SYSREF_IGN] |-> !sysref_evt_o)
        else $error("system reference event while ignored");

    AST_HOLD_DIS: assert property (@(posedge core_clk_i) disable iff (rst_i)
        link_dis |=> (oct_r == 3'h0 && frm_r == 5'h00 && lane_en_o == 4'h0))
        else $error("link runs while disabled");

    AST_RELEASE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ($fell(link_dis) && !rate_over) |-> link_active_o ##1 (oct_r == 3'h1 || f_last == 3'h0))
        else $error("link did not start after enable");

    AST_QC_44: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (link_dis && qc_r == 8'h44) |=> (cfg_r.l == 8'h04 && cfg_r.f == 8'h02 && cfg_r.m == 8'h04))
        else $error("quick config 0x44 not applied");

    AST_MSB_FIRST: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (active && cfg_r.f == 8'h02 && oct_r == 3'h0 && sel[0] == 2'h0)
        |-> (lg_oct[0] == smp_r[0][15:8]) ##1 (lg_oct[0] == smp_r[0][7:0] || !active))
        else $error("two-octet frame not MSB then LSB");

    AST_RATE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        rate_over |-> !link_active_o)
        else $error("link active above lane rate limit");

endmodule : sla_link_top

// File: sla_rx_model.sv
`timescale 1ns/1ns
module sla_rx_model (
    input  wire logic              core_clk_i,
    input  wire logic              clr_i,
    input  wire sla_pkg::sla_oct_s oct_i,
    output int                     n7_o,
    output int                     n3_o
);
    // Receiver tallies alignment marks on lane 0 to confirm frame lock
    always_ff @(posedge core_clk_i)
    begin
        if (clr_i)
        begin
            n7_o <= 0;
            n3_o <= 0;
        end
        else if (oct_i.k)
        begin
            n7_o <= n7_o + int'(oct_i.data == sla_pkg::K28_7);
            n3_o <= n3_o + int'(oct_i.data == sla_pkg::K28_3);
        end
    end
endmodule : sla_rx_model

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk = 0, rst = 1, we = 0, syn_n = 1, clr = 1, sref = 0;
    logic [7:0] addr = 0, wd = 0, rd, swing;
    logic [3:0][15:0] smp = '0;
    logic take, sreq, sevt, act, over;
    logic [3:0] len, inv;
    sla_pkg::sla_oct_s [3:0] oct;
    int n_errors = 0, total_checks = 0, n7, n3;
    // Rows: quick code, M, L, F; 0x44 last so lane 0 runs F=2 afterwards
    logic [7:0] tbl [6][4] = '{'{8'h41, 4, 1, 8}, '{8'h42, 4, 2, 4}, '{8'h22, 2, 2, 2},
                               '{8'h21, 2, 1, 4}, '{8'h11, 1, 1, 2}, '{8'h44, 4, 4, 2}};

    sla_link_top i_sla_link_top (.core_clk_i(clk), .rst_i(rst), .reg_we_i(we), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_rdata_o(rd), .samples_i(smp), .sample_take_o(take),
        .sync_req_n_i(syn_n), .sysref_i(sref), .sync_req_o(sreq), .sysref_evt_o(sevt),
        .link_active_o(act), .rate_over_o(over), .lane_en_o(len), .lane_octet_o(oct),
        .lane_invert_o(inv), .drive_swing_o(swing));
    sla_rx_model i_sla_rx_model (.core_clk_i(clk), .clr_i(clr), .oct_i(oct[0]), .n7_o(n7), .n3_o(n3));

    initial forever #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_b(input logic [7:0] g, e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk_b
    task automatic chk_n(input int g, e);
        total_checks++;
        if (g != e)
        begin
            n_errors++;
            $display("MISMATCH t=%0t count %0d exp %0d", $time, g, e);
        end
    endtask : chk_n
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk) #1 we = 1;
        addr = a;
        wd = d;
        @(posedge clk) #1 we = 0;
    endtask : wr
    task automatic rc(input logic [7:0] a, e);
        @(posedge clk) #1 addr = a;
        @(posedge clk) #1 chk_b(rd, e);
    endtask : rc
    // Exactly 128 cycles at F=2 hold 64 frame ends and 2 multiframe ends
    task automatic repl(input logic [7:0] scr, ctl, lsb, input int e7, e3);
        wr(8'h5f, 8'h11);
        wr(8'h6e, scr);
        wr(8'h5f, ctl);
        smp = {4{8'ha0, lsb}};
        repeat (8) @(posedge clk);
        #1 clr = 0;
        repeat (128) @(posedge clk);
        #1 clr = 1;
        chk_n(n7, e7);
        chk_n(n3, e3);
        $display("test repl done");
    endtask : repl
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #60000 n_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        #1 rst = 0;
        @(posedge clk) #1 chk_b({3'h0, act, len}, 8'h13);
        rc(8'h14, 8'h01);
        rc(8'h82, 8'h10);
        rc(8'h83, 8'h32);
        rc(8'h20, 8'h00);
        wr(8'h60, 8'h02);
        chk_b({4'h0, inv}, 8'h0f);
        wr(8'h60, 8'h00);
        chk_b({4'h0, inv}, 8'h00);
        wr(8'h14, 8'h00);
        rc(8'h14, 8'h00);
        wr(8'h15, 8'h01);
        chk_b(swing, 8'h01);
        syn_n = 0;
        repeat (4) @(posedge clk);
        #1 chk_b({7'h0, sreq}, 8'h01);
        wr(8'h3a, 8'h08);
        repeat (4) @(posedge clk);
        #1 chk_b({7'h0, sreq}, 8'h00);
        // Event pulse stands one cycle, two edges after the pin rises
        sref = 1;
        repeat (2) @(posedge clk);
        #1 chk_b({7'h0, sevt}, 8'h01);
        @(posedge clk) #1 chk_b({7'h0, sevt}, 8'h00);
        wr(8'h3a, 8'h18);
        sref = 0;
        repeat (3) @(posedge clk);
        #1 sref = 1;
        repeat (2) @(posedge clk);
        #1 chk_b({7'h0, sevt}, 8'h00);
        $display("test regs done");
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h5f, 8'h11);
            chk_b({7'h0, act}, 8'h00);
            wr(8'h5e, tbl[i][0]);
            wr(8'h6f, 8'h00);
            rc(8'h71, tbl[i][1]);
            rc(8'h6e, 8'h80 | tbl[i][2]);
            rc(8'h6f, tbl[i][3]);
            rc(8'h74, 8'h01);
            rc(8'h75, 8'h00);
            wr(8'h5f, 8'h10);
            chk_b({6'h0, over, act}, (i == 0) ? 8'h02 : 8'h01);
        end
        $display("test config done");
        wr(8'h82, 8'h01);
        smp = 64'ha353_a252_a151_a050;
        // First take captures the new samples, the second shows them on the lanes
        for (int i = 0; i < 8 && take !== 1'b1; i++)
            @(posedge clk) #1;
        @(posedge clk) #1;
        for (int i = 0; i < 8 && take !== 1'b1; i++)
            @(posedge clk) #1;
        // Offset binary is still selected, so the sign bit leaves flipped
        chk_b(oct[0].data, 8'h21);
        chk_b(oct[1].data, 8'h20);
        @(posedge clk) #1 chk_b(oct[0].data, 8'h51);
        $display("test remap done");
        wr(8'h82, 8'h10);
        repl(8'h00, 8'h10, 8'h50, 62, 2);
        repl(8'h00, 8'h00, 8'h50, 64, 0);
        repl(8'h80, 8'h10, 8'hfc, 62, 0);
        repl(8'h80, 8'h10, 8'h7c, 0, 2);
        rst = 1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        @(posedge clk) #1 chk_b({3'h0, act, len}, 8'h13);
        rc(8'h14, 8'h01);
        $display("test reset done");
        wrap_up();
    end
endmodule : tb_top
